/* File: rtl/cks_defines.svh */
`ifndef CKS_DEFINES_SVH
`define CKS_DEFINES_SVH

// Codec address this codec answers to
`define CKS_CODEC_ADDR 4'h0

// Node identifiers
`define CKS_NODE_AFG 8'h01
`define CKS_NODE_DIG_OUT 8'h06
`define CKS_NODE_DIG_IN 8'h0A
`define CKS_NODE_KNOB 8'h21

// Verb identifiers
`define CKS_VERB_GET_CONV_CTL1 12'hF0D
`define CKS_VERB_GET_CONV_CTL2 12'hF0E
`define CKS_VERB_SET_CONV_CTL1 12'h70D
`define CKS_VERB_SET_CONV_CTL2 12'h70E
`define CKS_VERB_GET_KNOB 12'hF0F
`define CKS_VERB_SET_KNOB 12'h70F
`define CKS_VERB_GET_UNSOL 12'hF08
`define CKS_VERB_SET_UNSOL 12'h708
`define CKS_VERB_GET_SUBSYS 12'hF20
`define CKS_VERB_SET_SUBSYS_B0 12'h720
`define CKS_VERB_SET_SUBSYS_B1 12'h721
`define CKS_VERB_SET_SUBSYS_B2 12'h722
`define CKS_VERB_SET_SUBSYS_B3 12'h723

// Verb field positions
`define CKS_CAD_MSB 31
`define CKS_CAD_LSB 28
`define CKS_NODE_MSB 27
`define CKS_NODE_LSB 20
`define CKS_VID_MSB 19
`define CKS_VID_LSB 8

// Payload bit positions
`define CKS_DIG_ON_BIT 0
`define CKS_KNOB_DIRECT_BIT 7
`define CKS_UNSOL_EN_BIT 7
`define CKS_CC_MSB 6

// Reset values; subsystem value is arbitrary
`define CKS_SUBSYS_RESET 32'h5A5A0000
`define CKS_KNOB_DIRECT_RESET 1'b0
`define CKS_CTL_RESET 8'h00
`define CKS_UNSOL_RESET 7'h00

`endif

/* File: rtl/cks_pkg.sv */
`default_nettype none
package cks_pkg;
  typedef logic [31:0] cks_word_type;
  typedef logic [11:0] cks_verb_id_type;
  typedef logic [7:0] cks_node_type;
  typedef logic [6:0] cks_step_type;
endpackage
`default_nettype wire

/* File: rtl/cks_codec_verbs.sv */
// Summary of operation
// - Input converter control-1 bit 0 switches on.
// - Input converter control-2 set ignored; both control gets return the on bit 0.
// - Output converter stores both control sets; nodes other than the two converters ignore them.
// - Knob get returns direct flag, step count.
// - Direct 0: report changes when enabled, gain holds.
// - Direct 1: knob drives amplifier gain.
// - Knob set stores bit 7, zero response.
// - Only node 21h acts on knob verbs.
// - Subsystem get returns identifier bits 31:16, low 16 bits zero.
// - Four byte verbs load subsystem identity.
// - Only node 01h accepts subsystem sets.
// - No test or ATE mode.
`include "cks_defines.svh"
`default_nettype none
module cks_codec_verbs (
  input wire logic clock,
  input wire logic rst,
  input wire logic bitClock,
  input wire logic verbValid,
  input wire cks_pkg::cks_word_type verb,
  input wire cks_pkg::cks_step_type knobStep,
  output logic respValid,
  output cks_pkg::cks_word_type resp,
  output logic unsolValid,
  output cks_pkg::cks_word_type unsolData,
  output cks_pkg::cks_step_type ampGain,
  output logic digitalConverterOn,
  output logic [14:0] iecConverterControlWord
);
  import cks_pkg::*;

  // Verb field helpers
  function automatic cks_node_type nodeOf(input cks_word_type w);
    nodeOf = w[`CKS_NODE_MSB:`CKS_NODE_LSB];
  endfunction

  function automatic cks_verb_id_type verbIdOf(input cks_word_type w);
    verbIdOf = w[`CKS_VID_MSB:`CKS_VID_LSB];
  endfunction

  function automatic logic addressedToUs(input cks_word_type w);
    addressedToUs = (w[`CKS_CAD_MSB:`CKS_CAD_LSB] == `CKS_CODEC_ADDR);
  endfunction

  // The block has no test or ATE entry: no such port exists.
  // The link reset timing is the controller's duty; rst clears all but the subsystem identifier, which loads 5A5A0000h.

  // ---------------- Link clock domain ----------------
  cks_word_type verbHold;
  cks_word_type next_verbHold;
  logic reqToggle;
  logic next_reqToggle;
  logic ackSync1;
  logic ackSync2;
  logic ackSeen;
  logic next_respValid;
  cks_word_type next_resp;
  logic unsolSync1;
  logic unsolSync2;
  logic unsolSeen;
  logic next_unsolValid;
  cks_word_type next_unsolData;

  // Signals held stable by the core domain while toggles cross
  cks_word_type respHold;
  logic ackToggle;
  cks_word_type unsolHold;
  logic unsolToggle;

  // Link side: capture verb, return answer and unsolicited words
  always_comb begin
    next_verbHold = verbHold;
    next_reqToggle = reqToggle;
    next_respValid = 1'b0;
    next_resp = resp;
    next_unsolValid = 1'b0;
    next_unsolData = unsolData;
    // Verb held until the next one; one verb per frame keeps it stable
    if (verbValid) begin
      next_verbHold = verb;
      next_reqToggle = ~reqToggle;
    end
    if (ackSync2 != ackSeen) begin
      next_respValid = 1'b1;
      next_resp = respHold;
    end
    if (unsolSync2 != unsolSeen) begin
      next_unsolValid = 1'b1;
      next_unsolData = unsolHold;
    end
  end

  // Link side registers
  always_ff @(posedge bitClock or posedge rst) begin
    if (rst) begin
      verbHold <= 32'h00000000;
      reqToggle <= 1'b0;
      ackSync1 <= 1'b0;
      ackSync2 <= 1'b0;
      ackSeen <= 1'b0;
      respValid <= 1'b0;
      resp <= 32'h00000000;
      unsolSync1 <= 1'b0;
      unsolSync2 <= 1'b0;
      unsolSeen <= 1'b0;
      unsolValid <= 1'b0;
      unsolData <= 32'h00000000;
    end else begin
      verbHold <= next_verbHold;
      reqToggle <= next_reqToggle;
      ackSync1 <= ackToggle;
      ackSync2 <= ackSync1;
      ackSeen <= ackSync2;
      respValid <= next_respValid;
      resp <= next_resp;
      unsolSync1 <= unsolToggle;
      unsolSync2 <= unsolSync1;
      unsolSeen <= unsolSync2;
      unsolValid <= next_unsolValid;
      unsolData <= next_unsolData;
    end
  end

  // ---------------- Core clock domain ----------------
  logic reqSync1;
  logic reqSync2;
  logic reqSeen;
  cks_step_type knobSync1;
  cks_step_type knobSync2;
  cks_step_type knobVolume;
  logic knobDirect;
  logic unsolEnable;
  logic [5:0] unsolTag;
  cks_word_type subsysId;
  logic [7:0] outCtl1;
  logic [6:0] outCtl2;

  logic next_ackToggle;
  cks_word_type next_respHold;
  logic next_unsolToggle;
  cks_word_type next_unsolHold;
  cks_step_type next_ampGain;
  logic next_knobDirect;
  logic next_unsolEnable;
  logic [5:0] next_unsolTag;
  cks_word_type next_subsysId;
  logic [7:0] next_outCtl1;
  logic [6:0] next_outCtl2;
  logic next_digitalConverterOn;

  // Core: decode verbs, track knob, build answers
  always_comb begin
    cks_node_type nid;
    cks_verb_id_type vid;
    logic [7:0] pay;
    nid = nodeOf(verbHold);
    vid = verbIdOf(verbHold);
    pay = verbHold[7:0];
    next_ackToggle = ackToggle;
    next_respHold = respHold;
    next_unsolToggle = unsolToggle;
    next_unsolHold = unsolHold;
    next_ampGain = ampGain;
    next_knobDirect = knobDirect;
    next_unsolEnable = unsolEnable;
    next_unsolTag = unsolTag;
    next_subsysId = subsysId;
    next_outCtl1 = outCtl1;
    next_outCtl2 = outCtl2;
    next_digitalConverterOn = digitalConverterOn;

    // Knob movement: gain follows only in direct mode
    if (knobSync2 != knobVolume) begin
      if (knobDirect) begin
        next_ampGain = knobSync2;
      end else if (unsolEnable) begin
        // Back-to-back moves faster than a crossing may merge; knobs are slow
        next_unsolHold = {unsolTag, 18'h00000, 1'b0, knobSync2};
        next_unsolToggle = ~unsolToggle;
      end
    end

    // New verb from the link; foreign codec addresses get no answer
    if (reqSync2 != reqSeen && addressedToUs(verbHold)) begin
      next_respHold = 32'h00000000;
      next_ackToggle = ~ackToggle;
      unique case (vid)
        `CKS_VERB_SET_CONV_CTL1: begin
          if (nid == `CKS_NODE_DIG_IN) begin
            next_digitalConverterOn = pay[`CKS_DIG_ON_BIT];
          end else if (nid == `CKS_NODE_DIG_OUT) begin
            next_outCtl1 = pay;
          end
          // Any other node leaves state alone
        end
        `CKS_VERB_SET_CONV_CTL2: begin
          // Input converter payload is reserved and dropped
          if (nid == `CKS_NODE_DIG_OUT) begin
            next_outCtl2 = pay[`CKS_CC_MSB:0];
          end
        end
        `CKS_VERB_GET_CONV_CTL1, `CKS_VERB_GET_CONV_CTL2: begin
          if (nid == `CKS_NODE_DIG_OUT) begin
            next_respHold = {16'h0000, 1'b0, outCtl2, outCtl1};
          end else if (nid == `CKS_NODE_DIG_IN) begin
            next_respHold = {16'h0000, 8'h00, 7'h00, digitalConverterOn};
          end
        end
        `CKS_VERB_GET_KNOB: begin
          if (nid == `CKS_NODE_KNOB) begin
            next_respHold = {24'h000000, knobDirect, knobVolume};
          end
        end
        `CKS_VERB_SET_KNOB: begin
          if (nid == `CKS_NODE_KNOB) begin
            next_knobDirect = pay[`CKS_KNOB_DIRECT_BIT];
          end
        end
        `CKS_VERB_GET_UNSOL: begin
          if (nid == `CKS_NODE_KNOB) begin
            next_respHold = {24'h000000, unsolEnable, 1'b0, unsolTag};
          end
        end
        `CKS_VERB_SET_UNSOL: begin
          if (nid == `CKS_NODE_KNOB) begin
            next_unsolEnable = pay[`CKS_UNSOL_EN_BIT];
            next_unsolTag = pay[5:0];
          end
        end
        `CKS_VERB_GET_SUBSYS: begin
          if (nid == `CKS_NODE_AFG) begin
            next_respHold = {subsysId[31:16], 8'h00, 8'h00};
          end
        end
        `CKS_VERB_SET_SUBSYS_B0: begin
          if (nid == `CKS_NODE_AFG) begin
            next_subsysId[7:0] = pay;
          end
        end
        `CKS_VERB_SET_SUBSYS_B1: begin
          if (nid == `CKS_NODE_AFG) begin
            next_subsysId[15:8] = pay;
          end
        end
        `CKS_VERB_SET_SUBSYS_B2: begin
          if (nid == `CKS_NODE_AFG) begin
            next_subsysId[23:16] = pay;
          end
        end
        `CKS_VERB_SET_SUBSYS_B3: begin
          if (nid == `CKS_NODE_AFG) begin
            next_subsysId[31:24] = pay;
          end
        end
        default: begin
          // Unknown verbs answer zero so the controller never times out
          next_respHold = 32'h00000000;
        end
      endcase
    end
  end

  // Core registers; knob pins pass two flops before use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reqSync1 <= 1'b0;
      reqSync2 <= 1'b0;
      reqSeen <= 1'b0;
      knobSync1 <= 7'h00;
      knobSync2 <= 7'h00;
      knobVolume <= 7'h00;
      ackToggle <= 1'b0;
      respHold <= 32'h00000000;
      unsolToggle <= 1'b0;
      unsolHold <= 32'h00000000;
      ampGain <= 7'h00;
      knobDirect <= `CKS_KNOB_DIRECT_RESET;
      unsolEnable <= 1'b0;
      unsolTag <= 6'h00;
      subsysId <= `CKS_SUBSYS_RESET;
      outCtl1 <= `CKS_CTL_RESET;
      outCtl2 <= `CKS_UNSOL_RESET;
      digitalConverterOn <= 1'b0;
      iecConverterControlWord <= 15'h0000;
    end else begin
      reqSync1 <= reqToggle;
      reqSync2 <= reqSync1;
      reqSeen <= reqSync2;
      knobSync1 <= knobStep;
      knobSync2 <= knobSync1;
      knobVolume <= knobSync2;
      ackToggle <= next_ackToggle;
      respHold <= next_respHold;
      unsolToggle <= next_unsolToggle;
      unsolHold <= next_unsolHold;
      ampGain <= next_ampGain;
      knobDirect <= next_knobDirect;
      unsolEnable <= next_unsolEnable;
      unsolTag <= next_unsolTag;
      subsysId <= next_subsysId;
      outCtl1 <= next_outCtl1;
      outCtl2 <= next_outCtl2;
      digitalConverterOn <= next_digitalConverterOn;
      iecConverterControlWord <= {next_outCtl2, next_outCtl1};
    end
  end
endmodule
`default_nettype wire

/* File: test/cks_codec_verbs_asserts.sv */
`default_nettype none
module cks_codec_verbs_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic bitClock,
  input wire logic verbValid,
  input wire cks_pkg::cks_word_type verb,
  input wire cks_pkg::cks_step_type knobStep,
  input wire logic respValid,
  input wire cks_pkg::cks_word_type resp,
  input wire logic unsolValid,
  input wire cks_pkg::cks_word_type unsolData,
  input wire cks_pkg::cks_step_type ampGain
);
  timeunit 1ns;
  timeprecision 1ps;
  import cks_pkg::*;
  cks_word_type lastVerb;
  cks_word_type next_lastVerb;
  // Verb that the next answer belongs to; one verb in flight at a time
  always_comb next_lastVerb = verbValid ? verb : lastVerb;
  always_ff @(posedge bitClock or posedge rst) begin
    if (rst) lastVerb <= 32'h0;
    else lastVerb <= next_lastVerb;
  end
  sequence answerWin;
    ##[4:7] respValid;
  endsequence
  // Two clock domains here, so every assertion names its own clock
  answer_time_a: assert property (@(posedge bitClock) disable iff (rst)
    verbValid && verb[31:28] == 4'h0 |-> answerWin)
    else $error("answer late");
  knob_get_a: assert property (@(posedge bitClock) disable iff (rst)
    respValid && lastVerb[27:8] == 20'h21F0F |-> resp[31:8] == 24'h0)
    else $error("knob read upper bits");
  set_zero_a: assert property (@(posedge bitClock) disable iff (rst)
    respValid && lastVerb[19:16] == 4'h7 |-> resp == 32'h0)
    else $error("set answer not zero");
  subsys_get_a: assert property (@(posedge bitClock) disable iff (rst)
    respValid && lastVerb[27:8] == 20'h01F20 |-> resp[15:0] == 16'h0)
    else $error("identity low half");
  input_ctl_a: assert property (@(posedge bitClock) disable iff (rst)
    respValid && lastVerb[27:10] == {8'h0A, 10'h3C3} |-> resp[31:1] == 31'h0)
    else $error("input control bits");
  unsol_pulse_a: assert property (@(posedge bitClock) disable iff (rst)
    unsolValid |=> !unsolValid)
    else $error("unsol strobe long");
  unsol_form_a: assert property (@(posedge bitClock) disable iff (rst)
    unsolValid |-> unsolData[25:7] == 19'h0)
    else $error("unsol format");
  gain_follow_a: assert property (@(posedge clock) disable iff (rst)
    $changed(ampGain) |-> ampGain == $past(knobStep, 2) || ampGain == $past(knobStep, 3))
    else $error("gain not from knob");
endmodule
bind cks_codec_verbs cks_codec_verbs_asserts cks_codec_verbs_asserts_inst (.clock(clock),
  .rst(rst), .bitClock(bitClock), .verbValid(verbValid), .verb(verb), .knobStep(knobStep),
  .respValid(respValid), .resp(resp), .unsolValid(unsolValid), .unsolData(unsolData),
  .ampGain(ampGain));
`default_nettype wire

/* File: test/cks_link_host.sv */
`default_nettype none
module cks_link_host (
  input wire logic bitClock,
  output logic verbValid,
  output cks_pkg::cks_word_type verb,
  input wire logic respValid,
  input wire cks_pkg::cks_word_type resp
);
  timeunit 1ns;
  timeprecision 1ps;
  import cks_pkg::*;
  initial begin
    verbValid = 1'b0;
    verb = 32'h0;
  end
  // One verb a frame, next only after the answer; bounded wait
  task automatic xfer(input cks_word_type w, output cks_word_type r, output logic late);
    int n;
    @(posedge bitClock);
    verbValid <= 1'b1;
    verb <= w;
    @(posedge bitClock);
    verbValid <= 1'b0;
    verb <= ~w; // Released lines carry junk, never the old verb
    late = 1'b1;
    r = 32'h0;
    for (n = 0; n < 12 && late; n++) begin
      @(posedge bitClock);
      if (respValid === 1'b1) begin
        r = resp;
        late = 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: test/cks_codec_verbs_bench.sv */
`default_nettype none
module cks_codec_verbs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cks_pkg::*;
  logic clock = 1'b0;
  logic bitClock = 1'b0;
  logic bitClockRun = 1'b0;
  logic rst = 1'b1;
  logic verbValid, respValid, unsolValid, digitalConverterOn, late;
  logic [14:0] iecWord;
  int unsolCount = 0;
  cks_word_type verb, resp, unsolData, got, id, unsolWord;
  cks_step_type knobStep = 7'h00;
  cks_step_type ampGain, st;
  logic [7:0] pay;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 60480;
  always #12.5 clock = ~clock;
  // Link clock stands still until started
  always #24 bitClock = bitClockRun & ~bitClock;
  cks_codec_verbs cks_codec_verbs_inst (.clock(clock), .rst(rst), .bitClock(bitClock),
    .verbValid(verbValid), .verb(verb), .knobStep(knobStep), .respValid(respValid),
    .resp(resp), .unsolValid(unsolValid), .unsolData(unsolData), .ampGain(ampGain),
    .digitalConverterOn(digitalConverterOn), .iecConverterControlWord(iecWord));
  cks_link_host cks_link_host_inst (.bitClock(bitClock), .verbValid(verbValid),
    .verb(verb), .respValid(respValid), .resp(resp));
  // Strobe lasts one link cycle, so count it and keep its word
  always @(posedge bitClock) begin
    if (unsolValid === 1'b1) begin
      unsolCount <= unsolCount + 1;
      unsolWord <= unsolData;
    end
  end
  function automatic cks_word_type vb(cks_node_type nd, cks_verb_id_type vid, logic [7:0] p);
    return {4'h0, nd, vid, p};
  endfunction
  task automatic chk(input cks_word_type g, input cks_word_type e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // A lost answer ends the run
  task automatic cmd(input cks_word_type w, input cks_word_type e);
    cks_link_host_inst.xfer(w, got, late);
    if (late) begin
      n_fail++;
      results();
    end else begin
      chk(got, e);
    end
  endtask
  // New knob position, always different from the last; a lost effect ends the run
  task automatic turn(input logic direct);
    int seen;
    int n;
    seen = unsolCount;
    st = st ^ {1'b1, 6'($random(seed))};
    @(posedge clock) knobStep <= st;
    for (n = 0; n < 40 && (direct ? ampGain !== st : unsolCount == seen); n++) begin
      @(posedge bitClock);
    end
    if (n >= 40) begin
      n_fail++;
      results();
    end
  endtask
  initial begin
    st = 7'h00;
    repeat (40) @(posedge clock);
    rst <= 1'b0;
    repeat (800) @(posedge clock);
    bitClockRun <= 1'b1;
    id = $random(seed);
    for (int b = 3; b >= 0; b--) cmd(vb(8'h01, 12'h720 + 12'(b), id[8*b +: 8]), 32'h0);
    cmd(vb(8'h0A, 12'h723, ~id[31:24]), 32'h0);
    cmd(vb(8'h01, 12'hF20, 8'h00), {id[31:16], 16'h0});
    $display("identity test done");
    for (int k = 0; k < 4; k++) begin
      pay = 8'($random(seed));
      pay[0] = k[0];
      cmd(vb(8'h0A, 12'h70D, pay), 32'h0);
      cmd(vb(8'h05, 12'h70D, ~pay), 32'h0);
      cmd(vb(8'h0A, 12'h70E, ~pay), 32'h0);
      cmd(vb(8'h0A, 12'hF0E, 8'h00), {31'h0, pay[0]});
      chk({31'h0, digitalConverterOn}, {31'h0, pay[0]});
    end
    // Output converter keeps both control bytes and shows them on its port
    cmd(vb(8'h06, 12'h70D, pay), 32'h0);
    cmd(vb(8'h06, 12'h70E, ~pay), 32'h0);
    cmd(vb(8'h06, 12'hF0E, 8'h00), {17'h0, ~pay[6:0], pay});
    chk({17'h0, iecWord}, {17'h0, ~pay[6:0], pay});
    $display("converter test done");
    cmd(vb(8'h21, 12'h708, 8'h85), 32'h0);
    cmd(vb(8'h21, 12'hF08, 8'h00), 32'h85);
    cmd(vb(8'h22, 12'h70F, 8'h80), 32'h0);
    for (int k = 0; k < 3; k++) begin
      turn(1'b0);
      chk(unsolWord, {6'h05, 18'h0, 1'b0, st});
      chk(unsolCount, k + 1);
      chk({25'h0, ampGain}, 32'h0);
      cmd(vb(8'h21, 12'hF0F, 8'h00), {24'h0, 1'b0, st});
    end
    cmd(vb(8'h21, 12'h70F, 8'hFF), 32'h0);
    cmd(vb(8'h21, 12'hF0F, 8'h00), {24'h0, 1'b1, st});
    turn(1'b1);
    // Leave room for a stray report to cross before looking
    repeat (12) @(posedge bitClock);
    chk({25'h0, ampGain}, {25'h0, st});
    chk(unsolCount, 32'h00000003);
    // Reports off and gain back to software: a move must change nothing
    cmd(vb(8'h21, 12'h708, 8'h05), 32'h0);
    cmd(vb(8'h21, 12'h70F, 8'h00), 32'h0);
    @(posedge clock) knobStep <= st ^ 7'h40;
    repeat (12) @(posedge bitClock);
    chk(unsolCount, 32'h00000003);
    chk({25'h0, ampGain}, {25'h0, st});
    cmd(vb(8'h21, 12'hF0F, 8'h00), {24'h0, 1'b0, st ^ 7'h40});
    $display("knob test done");
    results();
  end
endmodule
`default_nettype wire
